// ### verilog/dpsr_regs.sv
// Register bank for charge pump, call-progress levels, power, PLLs and line status.
// Assumes a synchronous byte register port with read data one cycle later.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ns
`include "dpsr_params.svh"

module dpsr_regs
   import dpsr_pkg::*;
#(
   parameter logic [3:0] HOST_REVISION = 4'h5  // Arbitrary revision value
)(
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire dpsr_bus_req_type  bus_req,
   output logic [7:0]             rd_data,
   input  wire logic [1:0]        serial_mode,
   input  wire logic              offhook_request,
   input  wire logic [4:0]        line_sense_value,
   input  wire logic              link_error_event,
   input  wire logic              link_frame_locked,
   output logic                   charge_pump_on,
   output dpsr_cp_level_type      call_progress_out,
   output logic                   line_side_powerdown,
   output logic                   host_side_powerdown,
   output logic [7:0]             pll1_first_div,
   output logic [7:0]             pll1_second_div,
   output logic [3:0]             pll2_first_div,
   output logic [3:0]             pll2_second_div,
   output logic                   pll_extra_ratio_sel,
   output logic                   irq
);

   // Loop current decode of the line sense value
   function automatic logic [3:0] loop_decode(input logic [4:0] sense, input logic offhook);
      logic [3:0] code;
      code = sense[4:1];
      if (offhook && sense == `DPSR_SENSE_HIGH_EXC) begin
         code = `DPSR_CODE_HIGH_EXC;
      end else if (offhook && sense == `DPSR_SENSE_LOW_EXC) begin
         code = `DPSR_CODE_LOW_EXC;
      end
      return code;
   endfunction : loop_decode

   // Stored state
   logic       link_err;
   logic       frame_lock;
   logic [3:0] loop_code;
   logic [2:0] irq_status;
   logic [2:0] irq_enable;

   // Register 6 reset image, split into its fields at reset
   localparam logic [7:0] CALL_PROGRESS_OUT_RESET = `DPSR_RST_CALL_PROGRESS_OUT_PWR;

   // Address decode
   wire wr_call_progress_out  = bus_req.wr && bus_req.addr == `DPSR_OFS_CALL_PROGRESS_OUT_PWR;
   wire wr_p1a   = bus_req.wr && bus_req.addr == `DPSR_OFS_PLL1_FIRST;
   wire wr_p1b   = bus_req.wr && bus_req.addr == `DPSR_OFS_PLL1_SECOND;
   wire wr_p2    = bus_req.wr && bus_req.addr == `DPSR_OFS_PLL2;
   wire wr_cfg   = bus_req.wr && bus_req.addr == `DPSR_OFS_PLL_CFG;
   wire wr_stat  = bus_req.wr && bus_req.addr == `DPSR_OFS_LINE_STATUS;
   wire wr_clr   = bus_req.wr && bus_req.addr == `DPSR_OFS_IRQ_CLEAR;
   wire wr_en    = bus_req.wr && bus_req.addr == `DPSR_OFS_IRQ_ENABLE;

   // Line status next values
   // An error in the clearing cycle wins, so no error is lost
   wire [3:0] next_loop_code = loop_decode(line_sense_value, offhook_request);  // [R15] [R16] [R18]
   wire       err_clear      = wr_stat && !bus_req.wdata[`DPSR_BIT_LINK_ERR];
   wire       next_link_err  = link_error_event | (link_err & ~err_clear);       // [R13]

   // Interrupt events, set wins over clear
   wire [2:0] irq_events = {next_loop_code != loop_code,
                            link_frame_locked != frame_lock,
                            link_error_event};
   wire [2:0] irq_clr_mask = wr_clr ? bus_req.wdata[2:0] : 3'h0;
   wire [2:0] next_irq_status = irq_events | (irq_status & ~irq_clr_mask);

   // Register images for readback
   wire [7:0] call_progress_out_image = {charge_pump_on, call_progress_out.tx_level[1],
                            call_progress_out.rx_level[1], line_side_powerdown,
                            host_side_powerdown, 1'b0, call_progress_out.tx_level[0],
                            call_progress_out.rx_level[0]};                       // [R17]
   wire [7:0] status_image = {link_err, frame_lock, 2'h0, loop_code};         // [R14] [R17]

   // Read multiplexer
   logic [7:0] next_rd_data;
   always_comb begin
      next_rd_data = 8'h00;
      if (bus_req.rd) begin
         unique case (bus_req.addr)
            `DPSR_OFS_CALL_PROGRESS_OUT_PWR:    next_rd_data = call_progress_out_image;
            `DPSR_OFS_PLL1_FIRST:  next_rd_data = pll1_first_div;
            `DPSR_OFS_PLL1_SECOND: next_rd_data = pll1_second_div;
            `DPSR_OFS_PLL2:        next_rd_data = {pll2_first_div, pll2_second_div};
            `DPSR_OFS_PLL_CFG:     next_rd_data = {7'h00, pll_extra_ratio_sel};
            `DPSR_OFS_REVISION:    next_rd_data = {4'h0, HOST_REVISION};   // [R12]
            `DPSR_OFS_LINE_STATUS: next_rd_data = status_image;
            `DPSR_OFS_IRQ_STATUS:  next_rd_data = {5'h00, irq_status};
            `DPSR_OFS_IRQ_ENABLE:  next_rd_data = {5'h00, irq_enable};
            default:               next_rd_data = 8'h00;
         endcase
      end
   end

   // Control register 6
   // Host powerdown only leaves through reset; a zero write is ignored
   always_ff @(posedge clock) begin
      if (rst) begin
         charge_pump_on             <= CALL_PROGRESS_OUT_RESET[`DPSR_BIT_CHARGE_PUMP];  // [R7]
         call_progress_out.tx_level <= {CALL_PROGRESS_OUT_RESET[`DPSR_BIT_TX_MSB],
                                        CALL_PROGRESS_OUT_RESET[`DPSR_BIT_TX_LSB]};    // [R7]
         call_progress_out.rx_level <= {CALL_PROGRESS_OUT_RESET[`DPSR_BIT_RX_MSB],
                                        CALL_PROGRESS_OUT_RESET[`DPSR_BIT_RX_LSB]};    // [R7]
         line_side_powerdown        <= CALL_PROGRESS_OUT_RESET[`DPSR_BIT_LINE_PD];      // [R7]
         host_side_powerdown        <= CALL_PROGRESS_OUT_RESET[`DPSR_BIT_HOST_PD];      // [R7]
      end else if (wr_call_progress_out) begin
         charge_pump_on <= bus_req.wdata[`DPSR_BIT_CHARGE_PUMP];              // [R1]
         call_progress_out.tx_level <= {bus_req.wdata[`DPSR_BIT_TX_MSB],
                                        bus_req.wdata[`DPSR_BIT_TX_LSB]};   // [R2]
         call_progress_out.rx_level <= {bus_req.wdata[`DPSR_BIT_RX_MSB],
                                        bus_req.wdata[`DPSR_BIT_RX_LSB]};   // [R3]
         line_side_powerdown <= bus_req.wdata[`DPSR_BIT_LINE_PD];           // [R4] [R5]
         host_side_powerdown <= host_side_powerdown | bus_req.wdata[`DPSR_BIT_HOST_PD];  // [R6]
      end
   end

   // PLL divider and mode registers
   // The serial mode strap only matters while reset is high
   always_ff @(posedge clock) begin
      if (rst) begin
         pll1_first_div  <= `DPSR_RST_ZERO;
         pll1_second_div <= (serial_mode == `DPSR_SERIAL_MODE2) ?
                            `DPSR_RST_PLL1_SER2 : `DPSR_RST_PLL1_SECOND;   // [R9]
         {pll2_first_div, pll2_second_div} <= `DPSR_RST_ZERO;
         pll_extra_ratio_sel <= 1'b0;
      end else begin
         if (wr_p1a) pll1_first_div <= bus_req.wdata;                      // [R8]
         if (wr_p1b) pll1_second_div <= bus_req.wdata;                     // [R8]
         if (wr_p2) {pll2_first_div, pll2_second_div} <= bus_req.wdata;     // [R10]
         if (wr_cfg) pll_extra_ratio_sel <= bus_req.wdata[0];               // [R11]
      end
   end

   // Line status, interrupts and read data
   always_ff @(posedge clock) begin
      if (rst) begin
         link_err   <= 1'b0;
         frame_lock <= 1'b0;
         loop_code  <= 4'h0;
         irq_status <= 3'h0;
         irq_enable <= 3'h0;
         irq        <= 1'b0;
         rd_data    <= 8'h00;
      end else begin
         link_err   <= next_link_err;
         frame_lock <= link_frame_locked;                                   // [R14]
         loop_code  <= next_loop_code;
         irq_status <= next_irq_status;
         if (wr_en) irq_enable <= bus_req.wdata[2:0];
         irq        <= |(next_irq_status & (wr_en ? bus_req.wdata[2:0] : irq_enable));
         rd_data    <= next_rd_data;
      end
   end

   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence s_write(logic [7:0] ofs);
      bus_req.wr && bus_req.addr == ofs;
   endsequence

   sequence s_read(logic [7:0] ofs);
      bus_req.rd && bus_req.addr == ofs;
   endsequence

   a_host_pd_hold: assert property (host_side_powerdown |=> host_side_powerdown) // [R6]
      else $error("host powerdown cleared without reset");

   a_call_progress_out_reset: assert property (@(posedge clock) disable iff (1'b0)  // [R7]
                       rst |=> call_progress_out_image == `DPSR_RST_CALL_PROGRESS_OUT_PWR)
      else $error("register 6 reset value wrong");

   a_link_err_set: assert property (link_error_event |=> link_err ##1 link_err || $past(err_clear)) // [R13]
      else $error("link error not set or dropped early");

   a_link_err_clr: assert property (s_write(`DPSR_OFS_LINE_STATUS) ##0
                                    (!bus_req.wdata[7] && !link_error_event) |=> !link_err) // [R13]
      else $error("link error not cleared by zero write");

   a_rev_read: assert property (s_read(`DPSR_OFS_REVISION) |=> rd_data == {4'h0, HOST_REVISION}) // [R12]
      else $error("revision read wrong");

   a_cfg_rsvd: assert property (s_read(`DPSR_OFS_PLL_CFG) |=> rd_data[7:1] == 7'h00) // [R17]
      else $error("reserved bits not zero");

   a_loop_decode: assert property (##1 loop_code ==
                       loop_decode($past(line_sense_value), $past(offhook_request))) // [R15]
      else $error("loop code decode wrong");

   a_pll2_write: assert property (s_write(`DPSR_OFS_PLL2) |=>
                       pll2_first_div == $past(bus_req.wdata[7:4])
                       && pll2_second_div == $past(bus_req.wdata[3:0])) // [R10]
      else $error("PLL2 dividers not stored");

   a_pump_write: assert property (s_write(`DPSR_OFS_CALL_PROGRESS_OUT_PWR) |=>
                       charge_pump_on == $past(bus_req.wdata[7])
                       && call_progress_out.tx_level == {$past(bus_req.wdata[6]),
                                                         $past(bus_req.wdata[1])}) // [R1]
      else $error("register 6 write not applied");

   a_lock_shown: assert property (link_frame_locked ##1 link_frame_locked |-> frame_lock) // [R14]
      else $error("frame lock not reflected");

   a_frame_lock_drop: assert property (!link_frame_locked |=> !frame_lock) // [R14]
      else $error("frame lock shown without lock");

   a_err_write_one: assert property (s_write(`DPSR_OFS_LINE_STATUS) ##0  // [R13]
                       (bus_req.wdata[`DPSR_BIT_LINK_ERR] && link_err) |=> link_err)
      else $error("link error cleared by a one write");

   // Register 6 field sequences and checks
   sequence s_call_progress_out_write;
      s_write(`DPSR_OFS_CALL_PROGRESS_OUT_PWR);
   endsequence

   a_tx_level_write: assert property (s_call_progress_out_write |=>  // [R2]
                       call_progress_out.tx_level == {$past(bus_req.wdata[`DPSR_BIT_TX_MSB]),
                                                      $past(bus_req.wdata[`DPSR_BIT_TX_LSB])})
      else $error("transmit level not stored");

   a_rx_level_write: assert property (s_call_progress_out_write |=>  // [R3]
                       call_progress_out.rx_level == {$past(bus_req.wdata[`DPSR_BIT_RX_MSB]),
                                                      $past(bus_req.wdata[`DPSR_BIT_RX_LSB])})
      else $error("receive level not stored");

   a_line_pd_write: assert property (s_call_progress_out_write |=>  // [R4]
                       line_side_powerdown == $past(bus_req.wdata[`DPSR_BIT_LINE_PD]))
      else $error("line-side powerdown not stored");

   a_host_pd_set: assert property (s_call_progress_out_write ##0  // [R6]
                       bus_req.wdata[`DPSR_BIT_HOST_PD] |=> host_side_powerdown)
      else $error("host powerdown not set by write");

   a_host_pd_reset: assert property (@(posedge clock) disable iff (1'b0)  // [R6]
                       rst |=> !host_side_powerdown)
      else $error("host powerdown not cleared by reset");

   a_call_progress_out_rsvd: assert property (s_read(`DPSR_OFS_CALL_PROGRESS_OUT_PWR) |=> !rd_data[2])  // [R17]
      else $error("register 6 reserved bit not zero");

   a_pump_hold: assert property (!wr_call_progress_out |=> $stable(charge_pump_on))  // [R1]
      else $error("charge pump changed without a write");

   // PLL divider and mode checks
   a_pll1_first_write: assert property (s_write(`DPSR_OFS_PLL1_FIRST) |=>  // [R8]
                       pll1_first_div == $past(bus_req.wdata))
      else $error("first PLL1 divider not stored");

   a_pll1_second_write: assert property (s_write(`DPSR_OFS_PLL1_SECOND) |=>  // [R8]
                       pll1_second_div == $past(bus_req.wdata))
      else $error("second PLL1 divider not stored");

   a_pll_hold: assert property (!wr_p1a |=> $stable(pll1_first_div))  // [R8]
      else $error("first PLL1 divider changed without a write");

   a_pll1_reset_mode2: assert property (@(posedge clock) disable iff (1'b0)  // [R9]
                       rst && serial_mode == `DPSR_SERIAL_MODE2
                       |=> pll1_second_div == `DPSR_RST_PLL1_SER2)
      else $error("second PLL1 divider reset wrong in mode 2");

   a_pll1_reset_other: assert property (@(posedge clock) disable iff (1'b0)  // [R9]
                       rst && serial_mode != `DPSR_SERIAL_MODE2
                       |=> pll1_second_div == `DPSR_RST_PLL1_SECOND)
      else $error("second PLL1 divider reset wrong");

   a_pll_reset_zero: assert property (@(posedge clock) disable iff (1'b0)  // [R8] [R10] [R11]
                       rst |=> pll1_first_div == `DPSR_RST_ZERO
                       && {pll2_first_div, pll2_second_div} == `DPSR_RST_ZERO
                       && !pll_extra_ratio_sel)
      else $error("PLL registers not cleared by reset");

   a_ratio_write: assert property (s_write(`DPSR_OFS_PLL_CFG) |=>  // [R11]
                       pll_extra_ratio_sel == $past(bus_req.wdata[0]))
      else $error("clock mode bit not stored");

   // Line status readback and loop code exceptions
   sequence s_line_status_read;
      s_read(`DPSR_OFS_LINE_STATUS);
   endsequence

   a_status_read: assert property (s_line_status_read |=>  // [R14] [R17]
                       rd_data == {$past(link_err), $past(frame_lock), 2'h0,
                                   $past(loop_code)})
      else $error("line status read wrong");

   sequence s_offhook_high;
      offhook_request && line_sense_value == `DPSR_SENSE_HIGH_EXC;
   endsequence

   sequence s_offhook_low;
      offhook_request && line_sense_value == `DPSR_SENSE_LOW_EXC;
   endsequence

   sequence s_onhook_high;
      !offhook_request && line_sense_value == `DPSR_SENSE_HIGH_EXC;
   endsequence

   sequence s_onhook_low;
      !offhook_request && line_sense_value == `DPSR_SENSE_LOW_EXC;
   endsequence

   a_loop_high_exc: assert property (s_offhook_high |=>  // [R15] [R16]
                       loop_code == `DPSR_CODE_HIGH_EXC)
      else $error("off-hook high sense code wrong");

   a_loop_low_exc: assert property (s_offhook_low |=>  // [R15] [R16]
                       loop_code == `DPSR_CODE_LOW_EXC)
      else $error("off-hook low sense code wrong");

   a_loop_onhook_high: assert property (s_onhook_high |=>  // [R15] [R16]
                       loop_code == 4'hf)
      else $error("on-hook high sense code wrong");

   a_loop_onhook_low: assert property (s_onhook_low |=>  // [R15] [R16]
                       loop_code == 4'h0)
      else $error("on-hook low sense code wrong");

   // Interrupt status and line
   a_irq_err_set: assert property (link_error_event |=> irq_status[`DPSR_IRQ_LINK_ERR])  // [R13]
      else $error("link error interrupt not flagged");

   a_lock_irq_set: assert property (link_frame_locked != frame_lock |=>  // [R14]
                       irq_status[`DPSR_IRQ_LOCK_CHG])
      else $error("frame lock change not flagged");

   a_loop_irq_set: assert property (next_loop_code != loop_code |=>  // [R15]
                       irq_status[`DPSR_IRQ_LOOP_CHG])
      else $error("loop code change not flagged");

   a_irq_level: assert property (irq == |(irq_status & irq_enable))  // [R13]
      else $error("interrupt line disagrees with enabled status");

   a_irq_clear: assert property (s_write(`DPSR_OFS_IRQ_CLEAR) ##0  // [R13]
                       (bus_req.wdata[`DPSR_IRQ_LINK_ERR] && !link_error_event)
                       |=> !irq_status[`DPSR_IRQ_LINK_ERR])
      else $error("link error interrupt not cleared");

endmodule : dpsr_regs

// ### verilog/dpsr_params.svh
// Constants of the PLL, power and status register bank: offsets, fields, resets.
// Assumes a byte-wide register port and a 250 MHz single clock domain.
// What this block does
// R1 - Register 6 bit 7 enables the charge pump
// R2 - Bits 6,1 pick transmit call-progress attenuation
// R3 - Bits 5,0 pick receive call-progress attenuation
// R4 - Bit 4 holds line-side chip in low power
// R5 - Software programs clocks before clearing line powerdown
// R6 - Bit 3 powers host down until reset
// R7 - Register 6 resets to 0111_0000
// R8 - Registers 7, 8 hold PLL1 dividers minus one
// R9 - PLL1 second divider reset depends on serial mode
// R10 - Register 9 holds two PLL2 dividers minus one
// R11 - Register 10 bit 0 adds 25/16 ratio
// R12 - Register 11 returns revision, upper bits zero
// R13 - Link error bit sticks until zero written
// R14 - Register 12 bit 6 shows frame lock
// R15 - Loop code is sense bits 4:1, off-hook exceptions
// R16 - Off-hook state follows the off-hook control bit
// R17 - Reserved bits read zero, read-only writes ignored
// R18 - Line sense value arrives as an input
`ifndef DPSR_PARAMS_SVH
`define DPSR_PARAMS_SVH

// Register offsets
`define DPSR_OFS_CALL_PROGRESS_OUT_PWR    8'h06
`define DPSR_OFS_PLL1_FIRST  8'h07
`define DPSR_OFS_PLL1_SECOND 8'h08
`define DPSR_OFS_PLL2        8'h09
`define DPSR_OFS_PLL_CFG     8'h0a
`define DPSR_OFS_REVISION    8'h0b
`define DPSR_OFS_LINE_STATUS 8'h0c
`define DPSR_OFS_IRQ_STATUS  8'h20
`define DPSR_OFS_IRQ_CLEAR   8'h21
`define DPSR_OFS_IRQ_ENABLE  8'h22

// Field positions
`define DPSR_BIT_CHARGE_PUMP 7
`define DPSR_BIT_TX_MSB      6
`define DPSR_BIT_RX_MSB      5
`define DPSR_BIT_LINE_PD     4
`define DPSR_BIT_HOST_PD     3
`define DPSR_BIT_TX_LSB      1
`define DPSR_BIT_RX_LSB      0
`define DPSR_BIT_LINK_ERR    7
`define DPSR_BIT_FRAME_LOCK  6

// Reset values
`define DPSR_RST_CALL_PROGRESS_OUT_PWR    8'h70
`define DPSR_RST_PLL1_SECOND 8'h00
`define DPSR_RST_PLL1_SER2   8'h13
`define DPSR_RST_ZERO        8'h00
`define DPSR_SERIAL_MODE2    2'h2

// Loop code exceptions while off-hook
`define DPSR_SENSE_HIGH_EXC  5'h1e
`define DPSR_SENSE_LOW_EXC   5'h01
`define DPSR_CODE_HIGH_EXC   4'he
`define DPSR_CODE_LOW_EXC    4'h1

// Interrupt status bit positions
`define DPSR_IRQ_LINK_ERR    0
`define DPSR_IRQ_LOCK_CHG    1
`define DPSR_IRQ_LOOP_CHG    2

`endif

// ### verilog/dpsr_pkg.sv
// Types shared by the PLL, power and status register bank.
// Assumes the constants header is included alongside.
package dpsr_pkg;

   // One register port request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dpsr_bus_req_type;

   // Call-progress output levels
   typedef struct packed {
      logic [1:0] tx_level;
      logic [1:0] rx_level;
   } dpsr_cp_level_type;

endpackage : dpsr_pkg

// ### test/dpsr_link_model.sv
// Stand-in for the line-side link: error pulses, frame lock and line sense value.
// Assumes the bench sets the requests by non-blocking assignment at the rising edge.
`timescale 1ns/1ns
module dpsr_link_model (
   input  wire logic       clock,
   input  wire logic       err_req,
   input  wire logic       lock_req,
   input  wire logic [4:0] sense_req,
   output logic            link_error_event,
   output logic            link_frame_locked,
   output logic [4:0]      line_sense_value
);
   // Link outputs follow the requests one edge later
   always_ff @(posedge clock) begin
      link_error_event  <= err_req;
      link_frame_locked <= lock_req;
      line_sense_value  <= sense_req;
   end
endmodule : dpsr_link_model

// ### test/tb.sv
// Self-checking bench for the PLL, power and status register bank.
// Assumes one 250 MHz clock and the register port of the bank.
`timescale 1ns/1ns
module tb;
   import dpsr_pkg::*;
   logic             clock = 0;
   logic             rst = 1;
   dpsr_bus_req_type bus_req = '0;
   logic [1:0]       serial_mode = 2'h0;
   logic             offhook_request = 0;
   logic             err_req = 0;
   logic             lock_req = 0;
   logic [4:0]       sense_req = 5'h00;
   logic [7:0]       rd_data;
   logic             link_error_event, link_frame_locked, irq;
   logic [4:0]       line_sense_value;
   dpsr_cp_level_type cp;
   logic             cp_on, line_pd, host_pd, ratio;
   logic [7:0]       p1a, p1b;
   logic [3:0]       p2a, p2b;
   wire logic [7:0]  pins = {cp_on, cp, line_pd, host_pd, ratio};
   int               failures = 0;
   int               n_compared = 0;
   logic [4:0]       sv [5] = '{5'h1e, 5'h01, 5'h0a, 5'h1e, 5'h01};
   logic [3:0]       cd [5] = '{4'he, 4'h1, 4'h5, 4'hf, 4'h0};
   logic [4:0]       oh = 5'b00111;

   // Clock of 4 ns period
   always #2 clock = ~clock;

   dpsr_link_model u_link (.clock(clock), .err_req(err_req), .lock_req(lock_req),
      .sense_req(sense_req), .link_error_event(link_error_event),
      .link_frame_locked(link_frame_locked), .line_sense_value(line_sense_value));

   dpsr_regs u_dut (.clock(clock), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
      .serial_mode(serial_mode), .offhook_request(offhook_request),
      .line_sense_value(line_sense_value), .link_error_event(link_error_event),
      .link_frame_locked(link_frame_locked), .charge_pump_on(cp_on),
      .call_progress_out(cp), .line_side_powerdown(line_pd),
      .host_side_powerdown(host_pd), .pll1_first_div(p1a), .pll1_second_div(p1b),
      .pll2_first_div(p2a), .pll2_second_div(p2b), .pll_extra_ratio_sel(ratio), .irq(irq));

   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock) bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clock) bus_req <= '0;
      #1;
   endtask : wr

   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock) bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clock) bus_req <= '0;
      #1 chk("rd_data", e, rd_data);
   endtask : rd

   task do_reset(input logic [1:0] m);
      @(posedge clock) rst <= 1'b1;
      serial_mode <= m;
      repeat (16) @(posedge clock);
      rst <= 1'b0;
   endtask : do_reset

   task pulse_err;
      @(posedge clock) err_req <= 1'b1;
      @(posedge clock) err_req <= 1'b0;
      repeat (4) @(posedge clock);
      #1;
   endtask : pulse_err

   task finish_test;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : finish_test

   // Main sequence
   initial begin
      do_reset(2'h0);
      #1 chk("pins", 8'h54, pins);
      rd(8'h06, 8'h70);
      rd(8'h08, 8'h00);
      rd(8'h0b, 8'h05);
      rd(8'h0d, 8'h00);
      wr(8'h07, 8'ha5);
      wr(8'h08, 8'h3c);
      wr(8'h09, 8'ha5);
      wr(8'h0a, 8'hff);
      chk("pll1", 8'ha5, p1a);
      chk("pll1b", 8'h3c, p1b);
      chk("pll2", 8'ha5, {p2a, p2b});
      rd(8'h0a, 8'h01);
      wr(8'h0b, 8'hff);
      rd(8'h0b, 8'h05);
      wr(8'h06, 8'h82);
      chk("pins", 8'ha1, pins);
      wr(8'h06, 8'h61);
      chk("pins", 8'h59, pins);
      rd(8'h06, 8'h61);
      wr(8'h06, 8'h1c);
      chk("pins", 8'h07, pins);
      rd(8'h06, 8'h18);
      wr(8'h06, 8'h00);
      chk("pins", 8'h03, pins);
      for (int i = 0; i < 5; i++) begin
         @(posedge clock) offhook_request <= oh[i];
         sense_req <= sv[i];
         lock_req <= i[0];
         repeat (3) @(posedge clock);
         rd(8'h0c, {1'b0, i[0], 2'b00, cd[i]});
      end
      rd(8'h20, 8'h06);
      wr(8'h22, 8'h01);
      rd(8'h22, 8'h01);
      pulse_err();
      chk("irq", 8'h01, {7'h00, irq});
      wr(8'h0c, 8'h80);
      rd(8'h0c, 8'h80);
      wr(8'h0c, 8'h00);
      rd(8'h0c, 8'h00);
      wr(8'h21, 8'hff);
      rd(8'h20, 8'h00);
      chk("irq", 8'h00, {7'h00, irq});
      wr(8'h22, 8'h00);
      pulse_err();
      chk("irq", 8'h00, {7'h00, irq});
      rd(8'h0c, 8'h80);
      do_reset(2'h2);
      rd(8'h08, 8'h13);
      chk("pins", 8'h54, pins);
      finish_test();
   end
endmodule : tb
